// File: verilog/gca_pkg.sv
// Shared constants and carrier types for the converter control block
package gca_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;          // System clock rate
  localparam int unsigned DELAY_MAX_US = 32;            // Longest programmable delay in microseconds
  localparam int unsigned DELAY_MAX_CYC = (DELAY_MAX_US * (CLK_HZ / 1_000_000)); // 1600 cycles
  localparam int unsigned DELAY_W = 11;                 // Width of one delay field
  localparam int unsigned ATTN_SETTLE_NS = 1000;        // Attenuator settling time in ns
  localparam int unsigned ATTN_SETTLE_CYC = (ATTN_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CONV_PS = 62_500;             // Conversion phase in ps, one 16 MHz cycle
  localparam int unsigned CONV_CYC_RAW = (CONV_PS * (CLK_HZ / 1_000_000)) / 1_000_000;
  localparam int unsigned REG_SETTLE_US = 20;           // Regulator settling before any conversion
  localparam int unsigned REG_SETTLE_CYC = REG_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int unsigned SET_W = 6;                    // Settle counter width
  localparam int unsigned CNV_W = 3;                    // Conversion counter width

  // Trim and data layout
  localparam int unsigned TRIM_W = 10;                  // Width of each offset trim
  localparam logic [9:0] TRIM_MID = 10'h200;            // Mid-scale, no correction
  localparam logic [9:0] RESULT_MID = 10'h200;          // Ideal muted result

  // Delay reset values, staggered: regulator first, then sampler, then start
  localparam logic [10:0] DLY_REG_RST = 11'h000;
  localparam logic [10:0] DLY_SMP_RST = 11'h190;
  localparam logic [10:0] DLY_GO_RST = 11'h320;

  // Control word bits driven by software
  typedef struct packed {
    logic regulator_on;       // Converter regulator enable
    logic sampler_on;         // Sampler enable
    logic single_ended_select;// 1 single-ended, 0 differential
    logic input_mute;         // Input at centre scale
    logic polarity_swap;      // Swap input and output sign
    logic triple_range_attenuator; // 3x range request
    logic battery_select;     // Battery channel selected
    logic delay_counter_on;   // Delay counter enable
  } gca_ctrl_t;

  // Delay settings for the three delayed controls
  typedef struct packed {
    logic [10:0] regulator_dly;
    logic [10:0] sampler_dly;
    logic [10:0] go_dly;
  } gca_delay_t;

  // Settings handed to the analog converter network
  typedef struct packed {
    logic [9:0] offset_trim_pos;
    logic [9:0] offset_trim_neg;
    logic input_mute;
    logic polarity_swap;
    logic single_ended_select;
    logic attenuator;
  } gca_net_t;

endpackage : gca_pkg

// File: verilog/gca_delay_cnt.sv
// Delay counter that releases the regulator, sampler and start controls
module gca_delay_cnt
  import gca_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,        // Delay counter enabled
  input wire logic start_i,         // Start request while enabled
  input wire logic stop_i,          // Conversion finished
  input wire gca_delay_t delay_i,   // Programmed delays
  output logic [2:0] reached_o,     // Regulator, sampler, start delay reached
  output logic running_o            // Counter running
);

  logic [DELAY_W-1:0] count_r;      // Elapsed cycles
  logic run_r;                      // Counting
  logic [DELAY_W-1:0] thr [3];      // Thresholds in one array

  assign thr[0] = delay_i.regulator_dly;
  assign thr[1] = delay_i.sampler_dly;
  assign thr[2] = delay_i.go_dly;

  // Run state: start when enabled, stop on finish, cleared with enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
    end else if (!enable_i) begin
      run_r <= 1'b0;
    end else if (stop_i) begin
      run_r <= 1'b0;
    end else if (start_i) begin
      run_r <= 1'b1;
    end
  end

  // Count clock cycles; held after stop so it must be reset to reuse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (!enable_i) begin
      count_r <= '0;
    end else if (run_r && count_r != {DELAY_W{1'b1}}) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Each control is released once its count is reached
  generate
    for (genvar g = 0; g < 3; g++) begin : g_cmp
      assign reached_o[g] = (run_r || count_r != '0) && (count_r >= thr[g]);
    end
  endgenerate

  assign running_o = run_r;

endmodule // gca_delay_cnt

// File: verilog/gca_top.sv
// Converter control: offset trims, attenuator settling, staggered start-up
// Overview of operation
// - Trims feed the conversion network directly
// - Battery channel forces attenuator on
// - Conversion phase lasts at least three clock cycles
// - Delay counter delays three controls up to 32us
// - Delay reset values give staggered start-up
// - Counter starts on start write while enabled
// - Counter stops when conversion finishes
// - Clearing counter enable resets counter
// - Start ends sampling; ready clears start
// - Mute switches input to centre scale
// - Polarity swap inverts input and output sign
module gca_top
  import gca_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gca_ctrl_t ctrl_i,          // Software control bits
  input wire logic convert_go_set_i,     // Pulse: software writes 1 to start
  input wire logic trim_wr_i,            // Pulse: load both trims
  input wire logic [9:0] trim_pos_i,     // New positive trim
  input wire logic [9:0] trim_neg_i,     // New negative trim
  input wire logic delay_wr_i,           // Pulse: load delay settings
  input wire gca_delay_t delay_i,        // New delay settings
  input wire logic conv_done_i,          // Pin: analog comparator finished
  input wire logic [9:0] raw_result_i,   // Pin: raw comparator code
  output gca_net_t net_o,                // Settings to converter network
  output logic regulator_en_o,           // Delayed regulator enable
  output logic sampler_en_o,             // Delayed sampler enable
  output logic convert_o,                // Conversion phase active
  output logic convert_go_o,             // Start bit readback
  output logic settled_o,                // Attenuator settling complete
  output logic [9:0] conversion_result_o,// Latest result
  output logic result_valid_o,           // Pulse: new result
  output logic delay_counter_on_o,       // Enable readback
  output gca_delay_t delay_o             // Delay register readback
);

  // Conversion sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_ARM = 2'b01,
    ST_CONVERT = 2'b11,
    ST_DONE = 2'b10
  } gca_state_t;

  gca_state_t state_r, state_nxt;        // Sequencer state
  logic [1:0] done_sync_r;               // Two-stage synchroniser for done pin
  logic [9:0] raw_s1_r, raw_s2_r;        // Result synchroniser
  logic [SET_W-1:0] settle_r;            // Attenuator settle counter
  logic [CNV_W-1:0] conv_cnt_r;          // Conversion phase counter
  logic go_r;                            // Start bit
  logic atten;                           // Effective attenuator
  logic [2:0] reached;                   // Delay thresholds reached
  logic dly_run;                         // Delay counter running
  logic finish;                          // Conversion finished this cycle
  logic prev_chan_r;                     // Previous channel select for change detect

  // Battery channel forces the attenuator
  assign atten = ctrl_i.triple_range_attenuator | ctrl_i.battery_select;

  // Synchronise the analog done and result pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_sync_r <= 2'b00;
      raw_s1_r <= 10'h000;
      raw_s2_r <= 10'h000;
    end else begin
      done_sync_r <= {done_sync_r[0], conv_done_i};
      raw_s1_r <= raw_result_i;
      raw_s2_r <= raw_s1_r;
    end
  end

  // Trims held at mid-scale until software writes them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      net_o.offset_trim_pos <= TRIM_MID;
      net_o.offset_trim_neg <= TRIM_MID;
    end else if (trim_wr_i) begin
      net_o.offset_trim_pos <= trim_pos_i;
      net_o.offset_trim_neg <= trim_neg_i;
    end
  end

  // Mode bits passed to the network; mute and swap act in the analog path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      net_o.input_mute <= 1'b0;
      net_o.polarity_swap <= 1'b0;
      net_o.single_ended_select <= 1'b0;
      net_o.attenuator <= 1'b0;
    end else begin
      net_o.input_mute <= ctrl_i.input_mute;
      net_o.polarity_swap <= ctrl_i.polarity_swap;
      net_o.single_ended_select <= ctrl_i.single_ended_select;
      net_o.attenuator <= atten;
    end
  end

  // Delay registers; reset values stagger the start-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_o.regulator_dly <= DLY_REG_RST;
      delay_o.sampler_dly <= DLY_SMP_RST;
      delay_o.go_dly <= DLY_GO_RST;
    end else if (delay_wr_i) begin
      delay_o <= delay_i;
    end
  end

  // Settle counter restarts whenever channel or range changes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_r <= '0;
      prev_chan_r <= 1'b0;
    end else begin
      prev_chan_r <= ctrl_i.battery_select;
      if (prev_chan_r != ctrl_i.battery_select || !atten) begin
        settle_r <= '0;
      end else if (settle_r != SET_W'(ATTN_SETTLE_CYC)) begin
        settle_r <= settle_r + 1'b1;
      end
    end
  end

  // Readiness of the attenuator path, registered for the output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settled_o <= 1'b0;
    end else begin
      settled_o <= !atten || settle_r == SET_W'(ATTN_SETTLE_CYC);
    end
  end

  // Delay counter instance
  gca_delay_cnt u_dly (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(ctrl_i.delay_counter_on),
    .start_i(convert_go_set_i),
    .stop_i(finish),
    .delay_i(delay_o),
    .reached_o(reached),
    .running_o(dly_run)
  );

  // Delayed enables: without the counter, controls pass straight through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      regulator_en_o <= 1'b0;
      sampler_en_o <= 1'b0;
      delay_counter_on_o <= 1'b0;
    end else begin
      delay_counter_on_o <= ctrl_i.delay_counter_on;
      regulator_en_o <= ctrl_i.regulator_on &
                        (!ctrl_i.delay_counter_on | reached[0]);
      sampler_en_o <= ctrl_i.sampler_on &
                      (!ctrl_i.delay_counter_on | reached[1]);
    end
  end

  // Start bit: set by software, cleared by hardware when ready
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      go_r <= 1'b0;
    end else if (convert_go_set_i) begin
      go_r <= 1'b1;
    end else if (finish) begin
      go_r <= 1'b0;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SAMPLE: begin
        if (go_r) begin
          state_nxt = ST_ARM;
        end
      end
      ST_ARM: begin
        // Start held back until its delay has passed
        if (!ctrl_i.delay_counter_on || reached[2]) begin
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_cnt_r >= CNV_W'(CONV_CYC - 1) && done_sync_r[1]) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_SAMPLE;
      end
      default: begin
        state_nxt = ST_SAMPLE;
      end
    endcase
  end

  assign finish = (state_r == ST_DONE);

  // Sequencer state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_SAMPLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Conversion phase timer, same length with or without attenuator
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_cnt_r <= '0;
    end else if (state_r != ST_CONVERT) begin
      conv_cnt_r <= '0;
    end else if (conv_cnt_r != {CNV_W{1'b1}}) begin
      conv_cnt_r <= conv_cnt_r + 1'b1;
    end
  end

  // Outputs of the conversion path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      convert_o <= 1'b0;
      convert_go_o <= 1'b0;
      result_valid_o <= 1'b0;
      conversion_result_o <= 10'h000;
    end else begin
      convert_o <= (state_nxt == ST_CONVERT);
      convert_go_o <= go_r;
      result_valid_o <= (state_r == ST_CONVERT) && (state_nxt == ST_DONE);
      if ((state_r == ST_CONVERT) && (state_nxt == ST_DONE)) begin
        conversion_result_o <= raw_s2_r;
      end
    end
  end

  // Clearing enable stops the counter by the next cycle
  a_dly_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_i.delay_counter_on |=> !dly_run)
    else $error("delay counter ran with enable low");

  // Counter stops once conversion finishes
  a_dly_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    finish |=> !dly_run)
    else $error("delay counter kept running after finish");

  // Start while enabled starts the counter
  a_dly_start: assert property (@(posedge clk_i) disable iff (rst_i)
    convert_go_set_i && ctrl_i.delay_counter_on && !finish |=> dly_run)
    else $error("delay counter failed to start");

  // Hardware clears the start bit after finishing
  sequence s_finish;
    finish && !convert_go_set_i;
  endsequence
  a_go_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s_finish |=> ##1 !convert_go_o)
    else $error("start bit not cleared after conversion");

  // Battery channel always drives attenuator
  a_batt_atten: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.battery_select |=> net_o.attenuator)
    else $error("battery channel without attenuator");

  // Conversion phase lasts at least two cycles
  a_conv_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_r == ST_CONVERT) |-> (state_r == ST_CONVERT) [*2])
    else $error("conversion phase too short");

  // Not settled two cycles after a channel change
  a_settle_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    atten && $changed(ctrl_i.battery_select) |=> ##1 !settled_o)
    else $error("attenuator reported settled too early");

  // Held regulator stays off before its delay is reached
  a_dly_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.delay_counter_on && !reached[0] |=> !regulator_en_o)
    else $error("regulator released before its delay");

  // Positive trim loads on write
  a_trim_load: assert property (@(posedge clk_i) disable iff (rst_i)
    trim_wr_i |=> net_o.offset_trim_pos == $past(trim_pos_i))
    else $error("positive trim not loaded");

endmodule // gca_top

// File: dv/gca_top_bench.sv
// Self-checking bench for the converter control block: trims, settling, delay counter
module gca_top_bench
  import gca_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'b0;           // 50 MHz system clock
  logic rst_i = 1'b1;           // Asynchronous reset, held at start
  gca_ctrl_t ctrl;              // Software control bits
  logic go_set;                 // Start write pulse
  logic trim_wr;                // Trim load pulse
  logic delay_wr;               // Delay load pulse
  logic conv_done;              // Comparator finished pin
  logic [9:0] tpos;             // Positive trim to load
  logic [9:0] tneg;             // Negative trim to load
  logic [9:0] raw;              // Raw comparator code pin
  gca_delay_t dly;              // Delay settings to load
  gca_net_t net;                // Network settings seen
  logic reg_en, smp_en, conv, go_rb, settled, rvalid, dcon;
  logic [9:0] result;           // Latest result seen
  gca_delay_t dly_rb;           // Delay readback seen
  int n_errors;                 // Mismatches counted
  int checked;                  // Comparisons made
  logic [15:0] lfsr_r;          // Random source state

  gca_top dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl), .convert_go_set_i(go_set),
    .trim_wr_i(trim_wr), .trim_pos_i(tpos), .trim_neg_i(tneg), .delay_wr_i(delay_wr),
    .delay_i(dly), .conv_done_i(conv_done), .raw_result_i(raw), .net_o(net),
    .regulator_en_o(reg_en), .sampler_en_o(smp_en), .convert_o(conv),
    .convert_go_o(go_rb), .settled_o(settled), .conversion_result_o(result),
    .result_valid_o(rvalid), .delay_counter_on_o(dcon), .delay_o(dly_rb));

  // Clock generator, half period 10 ns
  always #10 clk_i = ~clk_i;

  // Step n rising edges, then land just after the last one so inputs change off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Single comparison point; four-state equality so an unknown matches only an unknown
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Sixteen-bit Fibonacci shift register step
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Load both trims and confirm they reach the converter network
  task automatic wr_trims(input logic [9:0] p, input logic [9:0] n);
    tpos = p;
    tneg = n;
    trim_wr = 1'b1;
    cyc(1);
    trim_wr = 1'b0;
    cyc(2);
    check(net.offset_trim_pos, p);
    check(net.offset_trim_neg, n);
  endtask

  // One conversion with the counter off: pin code in, result out, start bit cleared after
  task automatic convert(input logic [9:0] code, output logic [9:0] res);
    int n;
    int nc;
    n = 0;
    nc = 0;
    raw = code;
    cyc(3);
    go_set = 1'b1;
    conv_done = 1'b1;
    cyc(1);
    go_set = 1'b0;
    while (rvalid !== 1'b1 && n < 100) begin
      // Count the cycles spent in the conversion phase
      if (conv === 1'b1) begin
        nc++;
      end
      cyc(1);
      n++;
    end
    check(n < 100, 1);
    check(nc, CONV_CYC);
    res = result;
    conv_done = 1'b0;
    cyc(4);
    check(go_rb, 1'b0);
    check(conv, 1'b0);
  endtask

  // Start with the counter on and record when each delayed control rises
  task automatic measure(output int tr, output int ts, output int tc);
    tr = -1;
    ts = -1;
    tc = -1;
    go_set = 1'b1;
    conv_done = 1'b1;
    cyc(1);
    go_set = 1'b0;
    for (int t = 1; t < 200; t++) begin
      if (reg_en === 1'b1 && tr < 0) tr = t;
      if (smp_en === 1'b1 && ts < 0) ts = t;
      if (conv === 1'b1 && tc < 0) tc = t;
      cyc(1);
    end
    conv_done = 1'b0;
  endtask

  // Verdict and end of run; the only place the run stops
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the expected run of under two thousand cycles
  initial begin
    #(20 * 30000);
    n_errors++;
    $display("watchdog expired");
    conclude();
  end

  // Main sequence
  initial begin
    logic [9:0] res, offp, offn, p, n;
    logic [15:0] v;
    int tr, ts, tc, tr2, ts2, tc2;
    ctrl = '0;
    go_set = 1'b0;
    trim_wr = 1'b0;
    delay_wr = 1'b0;
    conv_done = 1'b0;
    tpos = 10'h000;
    tneg = 10'h000;
    raw = 10'h000;
    dly = '0;
    n_errors = 0;
    checked = 0;
    lfsr_r = 16'h730D;
    cyc(20);
    rst_i = 1'b0;
    cyc(1);
    check(net.offset_trim_pos, TRIM_MID);
    check(net.offset_trim_neg, TRIM_MID);
    check(dly_rb, {DLY_REG_RST, DLY_SMP_RST, DLY_GO_RST});
    check({reg_en, smp_en, conv, go_rb, rvalid, dcon}, 6'h00);
    $display("test reset values done");
    // Random control patterns must reach the network two cycles on
    for (int i = 0; i < 8; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      v = lfsr_r;
      ctrl.input_mute = v[0];
      ctrl.polarity_swap = v[1];
      ctrl.single_ended_select = v[2];
      ctrl.triple_range_attenuator = v[3];
      cyc(2);
      check(net.input_mute, v[0]);
      check(net.polarity_swap, v[1]);
      check(net.single_ended_select, v[2]);
      check(net.attenuator, v[3]);
      wr_trims(lfsr_r[9:0], lfsr_r[15:6]);
    end
    $display("test control passthrough done");
    // Battery channel forces the attenuator and restarts settling
    ctrl.triple_range_attenuator = 1'b0;
    cyc(3);
    check(settled, 1'b1);
    ctrl.battery_select = 1'b1;
    cyc(3);
    check(net.attenuator, 1'b1);
    check(settled, 1'b0);
    cyc(ATTN_SETTLE_CYC + 10);
    check(settled, 1'b1);
    ctrl.battery_select = 1'b0;
    cyc(3);
    check(net.attenuator, 1'b0);
    $display("test attenuator settling done");
    // Offset calibration in single-ended then differential mode
    ctrl.regulator_on = 1'b1;
    ctrl.sampler_on = 1'b1;
    cyc(REG_SETTLE_CYC);
    for (int se = 1; se >= 0; se--) begin
      lfsr_r = lfsr_next(lfsr_r);
      ctrl.single_ended_select = se[0];
      ctrl.input_mute = 1'b1;
      ctrl.polarity_swap = 1'b0;
      wr_trims(TRIM_MID, TRIM_MID);
      convert(RESULT_MID + {6'h00, lfsr_r[3:0]} + 10'h001, res);
      check(res, RESULT_MID + {6'h00, lfsr_r[3:0]} + 10'h001);
      offp = res - RESULT_MID;
      ctrl.polarity_swap = 1'b1;
      cyc(2);
      convert(RESULT_MID - offp, res);
      check(res, RESULT_MID - offp);
      offn = res - RESULT_MID;
      p = (se == 1) ? TRIM_MID - 10'(2 * offp) : TRIM_MID - offp;
      n = (se == 1) ? TRIM_MID - 10'(2 * offn) : TRIM_MID - offn;
      wr_trims(p, n);
      check({1'b0, p} + {1'b0, n}, {1'b0, TRIM_MID, 1'b0});
    end
    // Common-mode levels, then the muted check result near mid-scale
    wr_trims(10'h300, 10'h300);
    wr_trims(10'h100, 10'h100);
    wr_trims(TRIM_MID, TRIM_MID);
    convert(RESULT_MID, res);
    check(res, RESULT_MID);
    $display("test calibration done");
    // Delay counter: program, start, check stagger, reset, reuse
    ctrl = '0;
    dly = {11'h006, 11'h01E, 11'h03C};
    delay_wr = 1'b1;
    cyc(1);
    delay_wr = 1'b0;
    cyc(2);
    check(dly_rb, {11'h006, 11'h01E, 11'h03C});
    ctrl.delay_counter_on = 1'b1;
    ctrl.regulator_on = 1'b1;
    ctrl.sampler_on = 1'b1;
    cyc(2);
    check(dcon, 1'b1);
    measure(tr, ts, tc);
    check(tr >= 4 && tr <= 10, 1);
    check(ts >= 28 && ts <= 34, 1);
    check(tc >= 58 && tc <= 66, 1);
    check(tr < ts && ts < tc, 1);
    ctrl = '0;
    cyc(3);
    check(dcon, 1'b0);
    ctrl.delay_counter_on = 1'b1;
    ctrl.regulator_on = 1'b1;
    ctrl.sampler_on = 1'b1;
    cyc(2);
    measure(tr2, ts2, tc2);
    check({tr2[7:0], ts2[7:0], tc2[7:0]}, {tr[7:0], ts[7:0], tc[7:0]});
    check(go_rb, 1'b0);
    $display("test delay counter done");
    conclude();
  end
endmodule // gca_top_bench
